//--- src/phx_pkg.sv
/*
  Shared definitions for the prefetch hint executor: instruction field
  positions, opcodes, hint codes, action encodings and carrier structs.
  Assumes a 64-bit core pipeline and a data cache controller beside it.
*/
package phx_pkg;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int unsigned XLEN = 64;
  localparam int unsigned OPC_HI = 31;
  localparam int unsigned OPC_LO = 26;
  localparam int unsigned BASE_HI = 25;
  localparam int unsigned BASE_LO = 21;
  localparam int unsigned HINT_HI = 20;
  localparam int unsigned HINT_LO = 16;
  localparam int unsigned OFF9_HI = 15;
  localparam int unsigned OFF9_LO = 7;
  localparam int unsigned OFF16_HI = 15;
  localparam int unsigned OFF16_LO = 0;
  localparam int unsigned BIT6_POS = 6;
  localparam int unsigned FUNC_HI = 5;
  localparam int unsigned FUNC_LO = 0;
  localparam int unsigned OFF9_W = 9;
  localparam int unsigned OFF16_W = 16;

  localparam logic [5:0] EXT_OPCODE_GROUP = 6'h1F;
  localparam logic [5:0] FUNC_DATA_PREFETCH = 6'h35;
  localparam logic [5:0] FUNC_USER_PREFETCH = 6'h23;
  // Pre-Release-6 encoding of the ordinary prefetch (major opcode)
  localparam logic [5:0] LEGACY_DATA_PREFETCH_INSTR_OPCODE = 6'h33;

  // ----------------------------------------------------------------
  // Hint codes
  // ----------------------------------------------------------------
  localparam logic [4:0] HINT_L1_LRU = 5'h02;
  localparam logic [4:0] HINT_L1_IMPL = 5'h03;
  localparam logic [4:0] HINT_STORE_MASK = 5'h01;
  localparam logic [4:0] HINT_FIRST_RSVD = 5'h18;
  localparam logic [4:0] HINT_WB_INVAL = 5'h19;
  localparam logic [4:0] HINT_ZERO_FILL = 5'h1E;
  localparam logic [1:0] LEVEL_L1 = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACT_NONE,
    ACT_FETCH_LOAD,
    ACT_FETCH_STORE,
    ACT_WB_INVAL,
    ACT_ZERO_FILL,
    ACT_IMPL
  } phx_act_e;

  typedef struct packed {
    logic [31:0] word;
    logic [XLEN-1:0] base_val;
    logic kernel_mode;
  } phx_issue_s;

  typedef struct packed {
    logic [XLEN-1:0] vaddr;
    logic user_map;
  } phx_xlat_req_s;

  typedef struct packed {
    logic hit;
    logic valid;
    logic dirty;
    logic locked;
    logic cached;
    logic fault;
  } phx_xlat_rsp_s;

  typedef struct packed {
    phx_act_e act;
    logic [1:0] level;
    logic [4:0] hint;
    logic [XLEN-1:0] paddr;
    logic victim_wb;
  } phx_cache_cmd_s;

endpackage : phx_pkg

//--- src/phx_decode.sv
/*
  Combinational decoder for the prefetch instruction words.
  Assumes a word that the pipeline already marked valid.
*/
`timescale 1ns/1ps
module phx_decode
  import phx_pkg::*;
(
  input wire logic [31:0] word_in,
  input wire logic release6_in,
  output logic is_data_prefetch_instr_out,
  output logic is_user_out,
  output logic [4:0] hint_out,
  output logic [XLEN-1:0] offset_out
);
  import phx_pkg::*;

  // ----------------------------------------------------------------
  // Sign extension, one function per offset width
  // ----------------------------------------------------------------
  function automatic logic [XLEN-1:0] sext9(input logic [OFF9_W-1:0] v);
    sext9 = {{(XLEN-OFF9_W){v[OFF9_W-1]}}, v};
  endfunction : sext9

  function automatic logic [XLEN-1:0] sext16(input logic [OFF16_W-1:0] v);
    sext16 = {{(XLEN-OFF16_W){v[OFF16_W-1]}}, v};
  endfunction : sext16

  // Opcode match and offset selection
  always_comb
  begin
    logic grp;
    grp = (word_in[OPC_HI:OPC_LO] == EXT_OPCODE_GROUP) && !word_in[BIT6_POS];
    is_user_out = grp && (word_in[FUNC_HI:FUNC_LO] == FUNC_USER_PREFETCH);
    is_data_prefetch_instr_out = release6_in
      ? (grp && (word_in[FUNC_HI:FUNC_LO] == FUNC_DATA_PREFETCH))
      : (word_in[OPC_HI:OPC_LO] == LEGACY_DATA_PREFETCH_INSTR_OPCODE);
    hint_out = word_in[HINT_HI:HINT_LO];
    // Offset width depends on the release level and the user variant
    if (release6_in || is_user_out)
    begin
      offset_out = sext9(word_in[OFF9_HI:OFF9_LO]);
    end
    else
    begin
      offset_out = sext16(word_in[OFF16_HI:OFF16_LO]);
    end
  end

endmodule : phx_decode

//--- src/phx_hint_map.sv
/*
  Maps a hint code to a cache action and level.
  Assumes the caller owns release selection and exception reporting.
*/
`timescale 1ns/1ps
module phx_hint_map
  import phx_pkg::*;
#(
  parameter bit IMPL_L1_LRU = 1'b0
)
(
  input wire logic [4:0] hint_in,
  input wire logic release6_in,
  output phx_pkg::phx_act_e act_out,
  output logic [1:0] level_out,
  output logic resv_out
);
  import phx_pkg::*;

  // Hint classification
  always_comb
  begin
    logic [2:0] sub;
    sub = hint_in[2:0];
    act_out = ACT_NONE;
    level_out = LEVEL_L1;
    resv_out = 1'b0;
    if (release6_in)
    begin
      if (hint_in >= HINT_FIRST_RSVD)
      begin
        resv_out = 1'b1;
      end
      else
      begin
        level_out = hint_in[4:3];
        if (sub == HINT_L1_LRU[2:0] || sub == HINT_L1_IMPL[2:0])
        begin
          // Optional hints stay NOPs; only the LRU hint can be built in
          act_out = (IMPL_L1_LRU && sub == HINT_L1_LRU[2:0]) ? ACT_IMPL : ACT_NONE;
        end
        else
        begin
          act_out = (sub & HINT_STORE_MASK[2:0]) != 3'h0 ? ACT_FETCH_STORE : ACT_FETCH_LOAD;
        end
      end
    end
    else
    begin
      if (hint_in == HINT_WB_INVAL)
      begin
        act_out = ACT_WB_INVAL;
      end
      else if (hint_in == HINT_ZERO_FILL)
      begin
        act_out = ACT_ZERO_FILL;
      end
      else if (hint_in < HINT_L1_LRU || (hint_in >= 5'h04 && hint_in <= 5'h07))
      begin
        act_out = hint_in[0] ? ACT_FETCH_STORE : ACT_FETCH_LOAD;
      end
      else
      begin
        // Implementation-specific and reserved codes do nothing here
        act_out = ACT_NONE;
      end
    end
  end

endmodule : phx_hint_map

//--- src/phx_top.sv
/*
  Prefetch hint executor: takes one prefetch issue, forms and translates
  the effective address, classifies the hint and hands a cache command
  to the data cache controller, then reports completion.
  Hints are classified before any translation, so reserved and no-op
  codes never reach the translator or the cache controller.
  Assumes the pipeline holds ISSUE until DONE and the cache controller
  answers with a one-cycle completion pulse, and that the translator
  maps addresses one to one, so the command carries the request address.
*/
// Contract
// - Flush hint writes back dirty lines
// - Written-back lines become invalid afterwards
// - Locked line gets no flush action
// - Release 6 hints 24-31 raise exception
// - Legacy hints 26-29,31 implementation free
// - Zero-fill hit does nothing
// - Zero-fill miss: evict, zero, valid dirty
// - Never raise misalignment exception
// - Address is base plus sign-extended offset
// - Translate address as data load
// - Suppress all address and translation faults
// - Bus and cache errors reporting optional
// - Unsupported optional hints complete as NOP
// - Locked lines stay untouched
// - Missing translation moves no data
// - User variant decode: opcode, function, bit6
// - User variant uses user-mode mapping
// - Hints 8-23 target L2 and L3
// - Ordinary prefetch decode: opcode, function (code also requires bit6 clear; legacy build: opcode only)
// - Uncached access: no memory operation
`timescale 1ns/1ps
module phx_top
  import phx_pkg::*;
#(
  parameter bit RELEASE6 = 1'b1,
  parameter bit REPORT_ERRORS = 1'b0,
  parameter bit IMPL_L1_LRU = 1'b0,
  parameter bit INVAL_CLEAN = 1'b1
)
(
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  // Issue from the pipeline
  input wire logic ISSUE_VALID_IN,
  input wire phx_pkg::phx_issue_s ISSUE_IN,
  output logic ISSUE_READY_OUT,
  // Translation request and answer
  output logic XLAT_REQ_VALID_OUT,
  output phx_pkg::phx_xlat_req_s XLAT_REQ_OUT,
  input wire logic XLAT_RSP_VALID_IN,
  input wire phx_pkg::phx_xlat_rsp_s XLAT_RSP_IN,
  // Cache controller command and completion
  output logic CMD_VALID_OUT,
  output phx_pkg::phx_cache_cmd_s CMD_OUT,
  input wire logic CMD_DONE_IN,
  input wire logic CMD_ERROR_IN,
  // Completion report to the pipeline
  output logic DONE_OUT,
  output logic RESV_EXC_OUT,
  output logic ERR_EXC_OUT
);
  import phx_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XLAT,
    ST_CMD,
    ST_WAIT,
    ST_DONE
  } phx_state_e;

  // Decoder and hint map outputs, all combinational
  logic is_data_prefetch_instr;
  logic is_user;
  logic [4:0] hint;
  logic [XLEN-1:0] offset;
  phx_act_e map_act;
  logic [1:0] map_level;
  logic map_resv;

  // Field split and prefetch recognition
  phx_decode u_decode (
    .word_in (ISSUE_IN.word),
    .release6_in (RELEASE6),
    .is_data_prefetch_instr_out (is_data_prefetch_instr),
    .is_user_out (is_user),
    .hint_out (hint),
    .offset_out (offset)
  );

  // Hint to action and cache level
  phx_hint_map #(
    .IMPL_L1_LRU (IMPL_L1_LRU)
  ) u_hint_map (
    .hint_in (hint),
    .release6_in (RELEASE6),
    .act_out (map_act),
    .level_out (map_level),
    .resv_out (map_resv)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  // Each _q here is registered; each _d is its next value
  phx_state_e state_q, state_d;
  phx_act_e act_q, act_d;
  logic [1:0] level_q, level_d;
  logic [4:0] hint_q, hint_d;
  logic ready_q, ready_d;
  logic xreq_v_q, xreq_v_d;
  phx_xlat_req_s xreq_q, xreq_d;
  logic cmd_v_q, cmd_v_d;
  phx_cache_cmd_s cmd_q, cmd_d;
  logic done_q, done_d;
  logic resv_q, resv_d;
  logic err_q, err_d;

  // ----------------------------------------------------------------
  // Transaction walk
  // ----------------------------------------------------------------
  // Idle: ready stands high and a valid prefetch word is taken.
  // Reserved and no-op hints finish at once; the translator and the
  // cache never see them, so neither needs a cancel path.
  // Translate: the request level stands until the answer pulse.
  // A faulting, uncached or locked answer ends the prefetch quietly,
  // since an address problem must never become an exception.
  // Command: one spare cycle lets the final action settle before the
  // command level rises toward the cache controller.
  // Wait: the command level stands until the completion pulse; an
  // error with it is reported only when the build asks for that.
  // Done: one pulse, then one dead cycle before ready returns, so a
  // pipeline that drops valid with done is never taken twice.
  // Limitation: one prefetch in flight; issues wait for ready, and
  // a translator or cache that never answers stalls the sequencer.

  // Next-state logic for the whole transaction
  always_comb
  begin
    logic accept;
    logic [XLEN-1:0] ea;
    // Pulses drop, request levels drop, captured fields hold
    state_d = state_q;
    act_d = act_q;
    level_d = level_q;
    hint_d = hint_q;
    ready_d = 1'b0;
    xreq_v_d = 1'b0;
    xreq_d = xreq_q;
    cmd_v_d = 1'b0;
    cmd_d = cmd_q;
    done_d = 1'b0;
    resv_d = 1'b0;
    err_d = 1'b0;
    // Words that are not prefetches are ignored, never answered
    accept = ISSUE_VALID_IN && (is_data_prefetch_instr || is_user);
    // Wrap-around add; no alignment check is ever made
    ea = ISSUE_IN.base_val + offset;
    unique case (state_q)
      // Take a prefetch only while ready stands
      ST_IDLE:
      begin
        ready_d = 1'b1;
        if (ready_q && accept)
        begin
          ready_d = 1'b0;
          act_d = map_act;
          level_d = map_level;
          hint_d = hint;
          if (map_resv)
          begin
            // Exception only, nothing reaches the cache
            resv_d = 1'b1;
            done_d = 1'b1;
            state_d = ST_DONE;
          end
          else if (map_act == ACT_NONE)
          begin
            done_d = 1'b1;
            state_d = ST_DONE;
          end
          else
          begin
            xreq_v_d = 1'b1;
            xreq_d.vaddr = ea;
            // Kernel-mode user variant goes through user mapping
            xreq_d.user_map = is_user;
            state_d = ST_XLAT;
          end
        end
      end
      // Wait for the translation answer
      ST_XLAT:
      begin
        xreq_v_d = !XLAT_RSP_VALID_IN;
        if (XLAT_RSP_VALID_IN)
        begin
          // Fields come from registered copies, not the live issue
          cmd_d.act = act_q;
          cmd_d.level = level_q;
          cmd_d.hint = hint_q;
          cmd_d.paddr = xreq_q.vaddr;
          cmd_d.victim_wb = 1'b0;
          // Faults are swallowed; no data moves, no exception raised
          if (XLAT_RSP_IN.fault || !XLAT_RSP_IN.cached)
          begin
            done_d = 1'b1;
            state_d = ST_DONE;
          end
          else if (XLAT_RSP_IN.locked)
          begin
            // Lines locked by cache maintenance stay as they are
            done_d = 1'b1;
            state_d = ST_DONE;
          end
          else if (act_q == ACT_ZERO_FILL && XLAT_RSP_IN.hit)
          begin
            // Line already present; zeroing it would lose data
            done_d = 1'b1;
            state_d = ST_DONE;
          end
          else if (act_q == ACT_WB_INVAL && !XLAT_RSP_IN.hit)
          begin
            // Nothing cached at this address to flush
            done_d = 1'b1;
            state_d = ST_DONE;
          end
          else
          begin
            // Flush writes back when dirty; zero-fill evicts a dirty victim
            if (act_q == ACT_WB_INVAL)
            begin
              cmd_d.victim_wb = XLAT_RSP_IN.dirty;
              // Clean line invalidation is a build option
              if (!XLAT_RSP_IN.dirty && !INVAL_CLEAN)
              begin
                cmd_d.act = ACT_NONE;
              end
            end
            else if (act_q == ACT_ZERO_FILL)
            begin
              cmd_d.victim_wb = XLAT_RSP_IN.valid && XLAT_RSP_IN.dirty;
            end
            state_d = ST_CMD;
          end
        end
      end
      // Launch the settled command
      ST_CMD:
      begin
        if (cmd_q.act == ACT_NONE)
        begin
          done_d = 1'b1;
          state_d = ST_DONE;
        end
        else
        begin
          // Only zero-fill alters visible memory contents
          cmd_v_d = 1'b1;
          state_d = ST_WAIT;
        end
      end
      // Hold the command until the cache answers
      ST_WAIT:
      begin
        cmd_v_d = !CMD_DONE_IN;
        if (CMD_DONE_IN)
        begin
          // Error reporting is a build option
          err_d = REPORT_ERRORS && CMD_ERROR_IN;
          done_d = 1'b1;
          state_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // One idle cycle lets the pipeline drop ISSUE
        state_d = ST_IDLE;
      end
    endcase
    if (xreq_v_d == 1'b0 && state_q == ST_IDLE)
    begin
      xreq_d.vaddr = xreq_q.vaddr;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Registers only; reset loads constants
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_q <= ST_IDLE;
      act_q <= ACT_NONE;
      level_q <= LEVEL_L1;
      hint_q <= 5'h00;
      ready_q <= 1'b0;
      xreq_v_q <= 1'b0;
      xreq_q <= '0;
      cmd_v_q <= 1'b0;
      cmd_q <= '0;
      done_q <= 1'b0;
      resv_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      act_q <= act_d;
      level_q <= level_d;
      hint_q <= hint_d;
      ready_q <= ready_d;
      xreq_v_q <= xreq_v_d;
      xreq_q <= xreq_d;
      cmd_v_q <= cmd_v_d;
      cmd_q <= cmd_d;
      done_q <= done_d;
      resv_q <= resv_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ISSUE_READY_OUT = ready_q;
  assign XLAT_REQ_VALID_OUT = xreq_v_q;
  assign XLAT_REQ_OUT = xreq_q;
  assign CMD_VALID_OUT = cmd_v_q;
  assign CMD_OUT = cmd_q;
  assign DONE_OUT = done_q;
  assign RESV_EXC_OUT = resv_q;
  assign ERR_EXC_OUT = err_q;

endmodule : phx_top

//--- dv/phx_checker.sv
/*
  Port checker for the prefetch executor top.
  Assumes default parameters: Release 6 hints, errors unreported.
*/
`timescale 1ns/1ps
module phx_checker
  import phx_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic ISSUE_VALID_IN,
  input wire phx_pkg::phx_issue_s ISSUE_IN,
  input wire logic ISSUE_READY_OUT,
  input wire logic XLAT_REQ_VALID_OUT,
  input wire phx_pkg::phx_xlat_req_s XLAT_REQ_OUT,
  input wire logic XLAT_RSP_VALID_IN,
  input wire phx_pkg::phx_xlat_rsp_s XLAT_RSP_IN,
  input wire logic CMD_VALID_OUT,
  input wire phx_pkg::phx_cache_cmd_s CMD_OUT,
  input wire logic CMD_DONE_IN,
  input wire logic DONE_OUT,
  input wire logic RESV_EXC_OUT,
  input wire logic ERR_EXC_OUT
);
  import phx_pkg::*;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // ----------------------------------------------------------------
  // Decode of the word taken at acceptance
  // ----------------------------------------------------------------
  logic [5:0] fn;
  logic [4:0] hn;
  logic acc, rsv, nop, rsp, quiet;
  assign fn = ISSUE_IN.word[FUNC_HI:FUNC_LO];
  assign hn = ISSUE_IN.word[HINT_HI:HINT_LO];
  assign acc = ISSUE_VALID_IN && ISSUE_READY_OUT && ISSUE_IN.word[OPC_HI:OPC_LO] == EXT_OPCODE_GROUP
    && !ISSUE_IN.word[BIT6_POS] && (fn == FUNC_DATA_PREFETCH || fn == FUNC_USER_PREFETCH);
  assign rsv = hn[4:3] == 2'h3;
  assign nop = hn[2:1] == 2'h1 && !rsv;
  assign rsp = XLAT_REQ_VALID_OUT && XLAT_RSP_VALID_IN;
  // Any of these means the prefetch must not reach the cache
  assign quiet = XLAT_RSP_IN.fault || !XLAT_RSP_IN.cached || XLAT_RSP_IN.locked;

  property p_resv; acc && rsv |=> DONE_OUT && RESV_EXC_OUT && !XLAT_REQ_VALID_OUT; endproperty
  a_resv: assert property (p_resv) else $error("reserved hint mishandled");
  property p_nop; acc && nop |=> DONE_OUT && !RESV_EXC_OUT && !XLAT_REQ_VALID_OUT; endproperty
  a_nop: assert property (p_nop) else $error("optional hint not a no-op");
  property p_ea;
    acc && !rsv && !nop |=> XLAT_REQ_VALID_OUT && XLAT_REQ_OUT.vaddr ==
      $past(ISSUE_IN.base_val) + {{55{$past(ISSUE_IN.word[15])}}, $past(ISSUE_IN.word[15:7])};
  endproperty
  a_ea: assert property (p_ea) else $error("effective address wrong");
  property p_user;
    acc && !rsv && !nop && fn == FUNC_USER_PREFETCH && ISSUE_IN.kernel_mode |-> ##1 XLAT_REQ_OUT.user_map;
  endproperty
  a_user: assert property (p_user) else $error("user mapping not used");
  property p_noact; rsp && quiet |=> (DONE_OUT && !RESV_EXC_OUT) ##0 (!CMD_VALID_OUT) [*3]; endproperty
  a_noact: assert property (p_noact) else $error("cache touched without cause");
  property p_cmd;
    rsp && !quiet && !XLAT_RSP_IN.hit |-> ##2 CMD_VALID_OUT && CMD_OUT.paddr == $past(XLAT_REQ_OUT.vaddr, 2);
  endproperty
  a_cmd: assert property (p_cmd) else $error("cache command missing");
  property p_lvl;
    $rose(CMD_VALID_OUT) |-> CMD_OUT.level == CMD_OUT.hint[4:3]
      && CMD_OUT.act == (CMD_OUT.hint[0] ? ACT_FETCH_STORE : ACT_FETCH_LOAD);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level or action wrong");
  property p_fin; CMD_VALID_OUT && CMD_DONE_IN |=> DONE_OUT && !CMD_VALID_OUT ##2 ISSUE_READY_OUT; endproperty
  a_fin: assert property (p_fin) else $error("completion order wrong");
  property p_noerr; !ERR_EXC_OUT; endproperty
  a_noerr: assert property (p_noerr) else $error("unexpected error exception");
endmodule : phx_checker

bind phx_top phx_checker i_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
  .ISSUE_VALID_IN(ISSUE_VALID_IN), .ISSUE_IN(ISSUE_IN), .ISSUE_READY_OUT(ISSUE_READY_OUT),
  .XLAT_REQ_VALID_OUT(XLAT_REQ_VALID_OUT), .XLAT_REQ_OUT(XLAT_REQ_OUT), .XLAT_RSP_VALID_IN(XLAT_RSP_VALID_IN),
  .XLAT_RSP_IN(XLAT_RSP_IN), .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_OUT(CMD_OUT), .CMD_DONE_IN(CMD_DONE_IN),
  .DONE_OUT(DONE_OUT), .RESV_EXC_OUT(RESV_EXC_OUT), .ERR_EXC_OUT(ERR_EXC_OUT));

//--- dv/phx_far_model.sv
/*
  Translator and cache controller model facing the executor.
  Assumes requests are registered levels held until answered.
*/
`timescale 1ns/1ps
module phx_far_model
  import phx_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic xlat_req_valid_in,
  input wire logic cmd_valid_in,
  input wire phx_pkg::phx_xlat_rsp_s rsp_cfg_in,
  input wire logic [3:0] delay_in,
  input wire logic err_cfg_in,
  output phx_pkg::phx_xlat_rsp_s xlat_rsp_out,
  output logic xlat_rsp_valid_out,
  output logic cmd_done_out,
  output logic cmd_error_out
);
  // After each answer the data outputs show the inverse so stale values never look right
  initial
  begin
    xlat_rsp_valid_out = 1'b0;
    cmd_done_out = 1'b0;
    xlat_rsp_out = '0;
    cmd_error_out = 1'b0;
  end
  // Translation answer after a chosen stall
  always
  begin
    @(negedge clk_in);
    if (rst_b_in && xlat_req_valid_in)
    begin
      repeat (delay_in) @(negedge clk_in);
      xlat_rsp_out = rsp_cfg_in;
      xlat_rsp_valid_out = 1'b1;
      @(negedge clk_in);
      xlat_rsp_valid_out = 1'b0;
      xlat_rsp_out = ~rsp_cfg_in;
    end
  end
  // Cache command completion after the same stall
  always
  begin
    @(negedge clk_in);
    if (rst_b_in && cmd_valid_in)
    begin
      repeat (delay_in) @(negedge clk_in);
      cmd_error_out = err_cfg_in;
      cmd_done_out = 1'b1;
      @(negedge clk_in);
      cmd_done_out = 1'b0;
      cmd_error_out = ~err_cfg_in;
    end
  end
endmodule : phx_far_model

//--- dv/tb.sv
/*
  Self-checking bench for the prefetch executor at default parameters.
  Assumes the far model answers translation and cache commands.
*/
`timescale 1ns/1ps
module tb;
  import phx_pkg::*;
  logic clk, rst_b, iv, rdy, xv, xrv, cv, cdn, cer, dn, rx, ee, p_err, seen, resv, err;
  logic [3:0] p_dly;
  phx_issue_s iss;
  phx_xlat_req_s xreq, xq;
  phx_xlat_rsp_s xrsp, p_rsp;
  phx_cache_cmd_s cmd, cq;
  int mismatches, checks_done, nx, nc;

  phx_top i_dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .ISSUE_VALID_IN(iv), .ISSUE_IN(iss),
    .ISSUE_READY_OUT(rdy), .XLAT_REQ_VALID_OUT(xv), .XLAT_REQ_OUT(xreq), .XLAT_RSP_VALID_IN(xrv),
    .XLAT_RSP_IN(xrsp), .CMD_VALID_OUT(cv), .CMD_OUT(cmd), .CMD_DONE_IN(cdn), .CMD_ERROR_IN(cer),
    .DONE_OUT(dn), .RESV_EXC_OUT(rx), .ERR_EXC_OUT(ee));
  phx_far_model i_far (.clk_in(clk), .rst_b_in(rst_b), .xlat_req_valid_in(xv), .cmd_valid_in(cv),
    .rsp_cfg_in(p_rsp), .delay_in(p_dly), .err_cfg_in(p_err), .xlat_rsp_out(xrsp),
    .xlat_rsp_valid_out(xrv), .cmd_done_out(cdn), .cmd_error_out(cer));

  // 25 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Record requests seen at the far side
  always @(negedge clk)
  begin
    if (xv) begin nx++; xq = xreq; end
    if (cv) begin nc++; cq = cmd; end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
  endtask : chk
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
  endtask : chk_flag
  function automatic logic [31:0] mk(input logic [5:0] f, input logic [4:0] h, input logic [8:0] o);
    return {EXT_OPCODE_GROUP, 5'h03, h, o, 1'b0, f};
  endfunction : mk
  // Hold the issue until completion; a word never answered may be expected
  task automatic run(input logic [31:0] w, input logic [63:0] b, input logic k, input logic want);
    int i;
    nx = 0;
    nc = 0;
    seen = 1'b0;
    @(negedge clk);
    iv = 1'b1;
    iss = {w, b, k};
    for (i = 0; i < 40 && !seen; i++)
    begin
      @(negedge clk);
      if (dn === 1'b1) begin seen = 1'b1; resv = rx; err = ee; end
    end
    iv = 1'b0;
    chk_flag(seen, want);
    // A lost completion ends the whole test at once
    if (want && !seen)
    begin
      conclude();
    end
  endtask : run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every hint back to back, odd address and negative offset
  task automatic s_sweep();
    int h;
    logic rv, np;
    for (h = 0; h < 32; h++)
    begin
      rv = h >= 24;
      np = h[2:1] == 2'h1 && !rv;
      run(mk(FUNC_DATA_PREFETCH, h[4:0], 9'h1F0), 64'h1003, 1'b0, 1'b1);
      chk_flag(resv, rv);
      chk_flag(nx != 0, !(rv || np));
      chk_flag(nc != 0, !(rv || np));
      if (!(rv || np)) chk(xq.vaddr, 64'hFF3);
      if (!(rv || np)) chk(cq.paddr, 64'hFF3);
      if (!(rv || np)) chk(cq.level, h[4:3]);
      if (!(rv || np)) chk(cq.act, h[0] ? ACT_FETCH_STORE : ACT_FETCH_LOAD);
      if (!(rv || np)) chk(cq.hint, h[4:0]);
      if (!(rv || np)) chk_flag(xq.user_map, 1'b0);
    end
  endtask : s_sweep
  // Faulting, uncached and locked lines finish without a command
  task automatic s_noact();
    logic [5:0] r [3] = '{6'h03, 6'h00, 6'h26};
    int i;
    for (i = 0; i < 3; i++)
    begin
      p_rsp = r[i];
      run(mk(FUNC_DATA_PREFETCH, 5'h04, 9'h000), 64'h2000, 1'b0, 1'b1);
      chk_flag(resv, 1'b0);
      chk_flag(nc != 0, 1'b0);
    end
    p_rsp = 6'h02;
  endtask : s_noact
  // User variant from kernel mode, slow far side, bus error ignored
  task automatic s_user();
    p_dly = 4'h5;
    p_err = 1'b1;
    run(mk(FUNC_USER_PREFETCH, 5'h07, 9'h005), 64'h8000_0000_0000_0000, 1'b1, 1'b1);
    chk(xq.vaddr, 64'h8000_0000_0000_0005);
    chk_flag(xq.user_map, 1'b1);
    chk_flag(nc != 0, 1'b1);
    chk_flag(err, 1'b0);
    p_dly = 4'h0;
    p_err = 1'b0;
  endtask : s_user
  // Words that are not prefetches are never taken
  task automatic s_refuse();
    run(mk(6'h24, 5'h00, 9'h000), 64'h0, 1'b0, 1'b0);
    run(mk(FUNC_USER_PREFETCH, 5'h00, 9'h000) | 32'h40, 64'h0, 1'b0, 1'b0);
    chk_flag(nx != 0, 1'b0);
  endtask : s_refuse

  // Reset, then every scenario in turn
  initial
  begin
    rst_b = 1'b0;
    iv = 1'b0;
    iss = '0;
    p_rsp = 6'h02;
    p_dly = 4'h0;
    p_err = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    s_sweep();
    s_noact();
    s_user();
    s_refuse();
    conclude();
  end
endmodule : tb
